// File: core/dfc_pkg.sv
package dfc_pkg;

    // ********************************************************************
    // Bus and data widths
    // ********************************************************************
    localparam int DFC_DW = 32;
    localparam int DFC_AW = 6;
    localparam int DFC_W = 16;

    // ********************************************************************
    // Register byte offsets
    // ********************************************************************
    localparam logic [DFC_AW-1:0] DFC_OFF_CTRL = 6'h00;
    localparam logic [DFC_AW-1:0] DFC_OFF_BUS_FB1 = 6'h04;
    localparam logic [DFC_AW-1:0] DFC_OFF_BUS_FB2 = 6'h08;
    localparam logic [DFC_AW-1:0] DFC_OFF_SETPOINT1 = 6'h0c;
    localparam logic [DFC_AW-1:0] DFC_OFF_SETPOINT2 = 6'h10;
    localparam logic [DFC_AW-1:0] DFC_OFF_REF_MIN = 6'h14;
    localparam logic [DFC_AW-1:0] DFC_OFF_REF_MAX = 6'h18;
    localparam logic [DFC_AW-1:0] DFC_OFF_FB1 = 6'h1c;
    localparam logic [DFC_AW-1:0] DFC_OFF_FB2 = 6'h20;
    localparam logic [DFC_AW-1:0] DFC_OFF_FB_COMB = 6'h24;
    localparam logic [DFC_AW-1:0] DFC_OFF_REFERENCE = 6'h28;
    localparam logic [DFC_AW-1:0] DFC_OFF_ERROR = 6'h2c;
    localparam logic [DFC_AW-1:0] DFC_OFF_STATUS = 6'h30;

    // ********************************************************************
    // Modes and control layout
    // ********************************************************************
    typedef enum logic [2:0] {
        DFC_CMB_MIN = 3'h0,
        DFC_CMB_MAX = 3'h1,
        DFC_CMB_SUM = 3'h2,
        DFC_CMB_DIFF = 3'h3,
        DFC_CMB_AVG = 3'h4,
        DFC_CMB_ZONE_MIN = 3'h5,
        DFC_CMB_ZONE_MAX = 3'h6
    } dfc_combine_type;

    // Packed so that bit 0 is the transform and bit 6 the loop mode
    typedef struct packed {
        logic closed_loop;
        logic integrator_limit_hold_enable;
        logic regulation_direction_select;
        dfc_combine_type dual_feedback_combine_select;
        logic feedback_transform_select;
    } dfc_ctrl_type;

    typedef struct packed {
        logic limit_reached;
        logic signed [DFC_W-1:0] actual_freq;
    } dfc_drive_type;

    localparam logic [6:0] DFC_CTRL_RESET = 7'h22;
    localparam logic [DFC_W-1:0] DFC_SP_RESET = 16'h0000;
    localparam logic [DFC_W-1:0] DFC_BUS_FB_RESET = 16'h0000;
    localparam logic [DFC_W-1:0] DFC_REF_MIN_RESET = 16'h8000;
    localparam logic [DFC_W-1:0] DFC_REF_MAX_RESET = 16'h7fff;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int DFC_CLK_MHZ = 100;
    localparam int DFC_SAMPLE_NS = 10000;
    localparam int DFC_SAMPLE_CYC = DFC_SAMPLE_NS * DFC_CLK_MHZ / 1000;

endpackage : dfc_pkg

// File: core/dfc_combiner.sv
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Contract
// R1: Feedback one is bus feedback one plus scaled first voltage input.
// R2: Feedback two is bus feedback two plus scaled second voltage input.
// R3: Software must route both feedbacks to voltage inputs in two-zone modes.
// R4: Transform code 0 passes each feedback unchanged.
// R5: Transform code 1 replaces each feedback by its square root.
// R6: Feedback transform and combination run in open and closed loop alike; in open loop, codes 5 and 6 always select feedback one.
// R7: Resulting reference is remote reference plus setpoint one, compared to feedback.
// R8: Combine code 0 regulates on the lesser feedback.
// R9: Combine code 1, the reset value, regulates on the greater feedback.
// R10: Combine code 2 regulates on the sum of both feedbacks.
// R11: Combine code 3 regulates on feedback two minus feedback one.
// R12: Combine code 4 regulates on the mean of both feedbacks.
// R13: Code 5 forms both zone errors and selects the greater signed one.
// R14: In code 5 the selected zone's setpoint is added to remote reference.
// R15: Code 6 forms both zone errors and selects the smaller signed one.
// R16: In code 6 the selected zone's setpoint is added to remote reference.
// R17: Setpoint two only in closed loop two-zone; setpoints reset 0, clamped.
// R18: Software should not enable square root while a two-zone mode is set.
// R19: Direction 0 lowers frequency as feedback rises; 1 raises it.
// R20: Hold enable 1 reloads integrator with actual frequency at any limit.
// R21: A held integrator resumes once error is zero or changes sign.
// R22: Hold enable 0 keeps integrating through limits.
// R23: Arithmetic is signed and wide enough that sums never overflow.
module dfc_combiner #(
    parameter int W = dfc_pkg::DFC_W,
    parameter int SAMPLE_CYC = dfc_pkg::DFC_SAMPLE_CYC,
    parameter int IW = 28
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [dfc_pkg::DFC_AW-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [dfc_pkg::DFC_DW-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [dfc_pkg::DFC_DW-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic signed [W-1:0] analog1_in,
    input wire logic signed [W-1:0] analog2_in,
    input wire logic signed [W-1:0] remote_ref_in,
    input wire dfc_pkg::dfc_drive_type drive_in,
    output logic signed [W+3:0] feedback_out,
    output logic signed [W+3:0] reference_out,
    output logic signed [W+3:0] error_out,
    output logic signed [IW-1:0] integrator_out,
    output logic zone_two_out,
    output logic windup_hold_out
);
    import dfc_pkg::*;

    localparam int I = W + 4;
    localparam int CW = $clog2(SAMPLE_CYC + 1);
    localparam logic [CW-1:0] SAMPLE_LAST = CW'(SAMPLE_CYC - 1);

    // ********************************************************************
    // Helpers
    // ********************************************************************
    function automatic logic signed [I-1:0] dfc_ext(input logic [W-1:0] v);
        dfc_ext = I'(signed'(v));
    endfunction : dfc_ext

    // Integer square root, negative input gives zero
    function automatic logic signed [I-1:0] dfc_sqrt(input logic signed [I-1:0] v);
        logic [I-1:0] res;
        logic [I-1:0] trial;
        logic [2*I-1:0] sq;
        res = '0;
        trial = '0;
        sq = '0;
        if (v > 0) begin
            for (int k = I / 2 - 1; k >= 0; k--) begin
                trial = res | (I'(1) << k);
                sq = trial * trial;
                if (sq <= (2*I)'(unsigned'(v))) begin
                    res = trial;
                end
            end
        end
        dfc_sqrt = signed'(res);
    endfunction : dfc_sqrt

    function automatic logic signed [I-1:0] dfc_clamp(input logic signed [I-1:0] v,
                                                      input logic signed [I-1:0] lo,
                                                      input logic signed [I-1:0] hi);
        if (v < lo) begin
            dfc_clamp = lo;
        end else if (v > hi) begin
            dfc_clamp = hi;
        end else begin
            dfc_clamp = v;
        end
    endfunction : dfc_clamp

    function automatic logic [W-1:0] dfc_merge(input logic [W-1:0] old,
                                               input logic [DFC_DW-1:0] wd,
                                               input logic [3:0] be);
        dfc_merge = old;
        if (be[0]) begin
            dfc_merge[7:0] = wd[7:0];
        end
        if (be[1]) begin
            dfc_merge[W-1:8] = wd[W-1:8];
        end
    endfunction : dfc_merge

    // ********************************************************************
    // Register bus
    // ********************************************************************
    dfc_ctrl_type ctrl;
    logic [W-1:0] bus_fb1;
    logic [W-1:0] bus_fb2;
    logic [W-1:0] setpoint1;
    logic [W-1:0] setpoint2;
    logic [W-1:0] ref_min;
    logic [W-1:0] ref_max;
    logic bus_ack;
    logic wr_take;

    // One wait state: data is ready at the edge waitrequest is low
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~bus_ack;
    assign wr_take = avs_write_in & bus_ack;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (avs_read_in | avs_write_in) & ~bus_ack;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl <= dfc_ctrl_type'(DFC_CTRL_RESET);
            bus_fb1 <= DFC_BUS_FB_RESET;
            bus_fb2 <= DFC_BUS_FB_RESET;
            setpoint1 <= DFC_SP_RESET; // R17
            setpoint2 <= DFC_SP_RESET; // R17
            ref_min <= DFC_REF_MIN_RESET;
            ref_max <= DFC_REF_MAX_RESET;
        end else if (wr_take) begin
            case ({avs_address_in[DFC_AW-1:2], 2'b00})
                DFC_OFF_CTRL: begin
                    if (avs_byteenable_in[0]) begin
                        ctrl <= dfc_ctrl_type'(avs_writedata_in[6:0]);
                    end
                end
                DFC_OFF_BUS_FB1: begin
                    bus_fb1 <= dfc_merge(bus_fb1, avs_writedata_in, avs_byteenable_in);
                end
                DFC_OFF_BUS_FB2: begin
                    bus_fb2 <= dfc_merge(bus_fb2, avs_writedata_in, avs_byteenable_in);
                end
                DFC_OFF_SETPOINT1: begin
                    setpoint1 <= dfc_merge(setpoint1, avs_writedata_in, avs_byteenable_in);
                end
                DFC_OFF_SETPOINT2: begin
                    setpoint2 <= dfc_merge(setpoint2, avs_writedata_in, avs_byteenable_in);
                end
                DFC_OFF_REF_MIN: begin
                    ref_min <= dfc_merge(ref_min, avs_writedata_in, avs_byteenable_in);
                end
                DFC_OFF_REF_MAX: begin
                    ref_max <= dfc_merge(ref_max, avs_writedata_in, avs_byteenable_in);
                end
                default: begin
                end
            endcase
        end
    end

    // ********************************************************************
    // Feedback forming and transform
    // ********************************************************************
    logic signed [I-1:0] raw_fb1;
    logic signed [I-1:0] raw_fb2;
    logic signed [I-1:0] fb1;
    logic signed [I-1:0] fb2;

    // No loop-mode gating here so open loop can still display feedback
    always_comb begin // R6
        raw_fb1 = dfc_ext(bus_fb1) + dfc_ext(analog1_in); // R1 R23
        raw_fb2 = dfc_ext(bus_fb2) + dfc_ext(analog2_in); // R2 R23
        if (ctrl.feedback_transform_select) begin
            fb1 = dfc_sqrt(raw_fb1); // R5
            fb2 = dfc_sqrt(raw_fb2); // R5
        end else begin
            fb1 = raw_fb1; // R4
            fb2 = raw_fb2; // R4
        end
    end

    // ********************************************************************
    // Combination and setpoint selection
    // ********************************************************************
    logic signed [I-1:0] sp1c;
    logic signed [I-1:0] sp2c;
    logic signed [I-1:0] err1;
    logic signed [I-1:0] err2;
    logic signed [I-1:0] fb_sum;
    logic signed [I-1:0] next_fb;
    logic signed [I-1:0] next_ref;
    logic signed [I-1:0] next_err;
    logic signed [I-1:0] raw_err;
    logic next_zone_two;

    always_comb begin
        sp1c = dfc_clamp(dfc_ext(setpoint1), dfc_ext(ref_min), dfc_ext(ref_max)); // R17
        sp2c = dfc_clamp(dfc_ext(setpoint2), dfc_ext(ref_min), dfc_ext(ref_max)); // R17
        err1 = sp1c - fb1;
        err2 = sp2c - fb2;
        fb_sum = fb1 + fb2;
        next_zone_two = 1'b0;
        case (ctrl.dual_feedback_combine_select)
            DFC_CMB_MIN: begin
                next_fb = (fb1 < fb2) ? fb1 : fb2; // R8
            end
            DFC_CMB_MAX: begin
                next_fb = (fb1 > fb2) ? fb1 : fb2; // R9
            end
            DFC_CMB_SUM: begin
                next_fb = fb_sum; // R10
            end
            DFC_CMB_DIFF: begin
                next_fb = fb2 - fb1; // R11
            end
            DFC_CMB_AVG: begin
                next_fb = fb_sum >>> 1; // R12
            end
            DFC_CMB_ZONE_MIN: begin
                // Signed compare: a positive error always beats a negative one
                next_zone_two = ctrl.closed_loop & (err2 > err1); // R13 R17
                next_fb = next_zone_two ? fb2 : fb1; // R14
            end
            DFC_CMB_ZONE_MAX: begin
                next_zone_two = ctrl.closed_loop & (err2 < err1); // R15 R17
                next_fb = next_zone_two ? fb2 : fb1; // R16
            end
            default: begin
                next_fb = (fb1 > fb2) ? fb1 : fb2;
            end
        endcase
        next_ref = dfc_ext(remote_ref_in) + (next_zone_two ? sp2c : sp1c); // R7 R14 R16
        raw_err = next_ref - next_fb; // R7
        // Normal: rising feedback shrinks the error and so the frequency
        next_err = ctrl.regulation_direction_select ? -raw_err : raw_err; // R19
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            feedback_out <= '0;
            reference_out <= '0;
            error_out <= '0;
            zone_two_out <= 1'b0;
        end else begin
            feedback_out <= next_fb;
            reference_out <= next_ref;
            error_out <= next_err;
            zone_two_out <= next_zone_two;
        end
    end

    // ********************************************************************
    // Sample rate divider
    // ********************************************************************
    logic [CW-1:0] div_cnt;
    logic sample_en;

    assign sample_en = (div_cnt == SAMPLE_LAST);

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            div_cnt <= '0;
        end else if (sample_en) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + CW'(1);
        end
    end

    // ********************************************************************
    // Integrator with limit hold
    // ********************************************************************
    typedef enum logic [1:0] {
        DFC_AW_RUN = 2'b00,
        DFC_AW_HOLD = 2'b01
    } dfc_aw_state_type;

    dfc_aw_state_type aw_state;
    logic hold_sign;
    logic err_sign;
    logic err_zero;

    assign err_sign = error_out[I-1];
    assign err_zero = (error_out == '0);

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_state <= DFC_AW_RUN;
            hold_sign <= 1'b0;
            integrator_out <= '0;
        end else if (sample_en) begin
            case (aw_state)
                DFC_AW_RUN: begin
                    if (ctrl.integrator_limit_hold_enable && drive_in.limit_reached) begin
                        integrator_out <= IW'(drive_in.actual_freq); // R20
                        hold_sign <= err_sign;
                        aw_state <= DFC_AW_HOLD;
                    end else begin
                        // Without hold the sum winds through limits
                        integrator_out <= integrator_out + IW'(error_out); // R22
                    end
                end
                DFC_AW_HOLD: begin
                    if (drive_in.limit_reached && ctrl.integrator_limit_hold_enable) begin
                        integrator_out <= IW'(drive_in.actual_freq); // R20
                    end
                    if (!ctrl.integrator_limit_hold_enable) begin
                        aw_state <= DFC_AW_RUN;
                    end else if (err_zero || (err_sign != hold_sign)) begin
                        aw_state <= DFC_AW_RUN; // R21
                    end
                end
                default: begin
                    aw_state <= DFC_AW_RUN;
                end
            endcase
        end
    end

    assign windup_hold_out = (aw_state == DFC_AW_HOLD);

    // ********************************************************************
    // Read data
    // ********************************************************************
    logic [DFC_DW-1:0] next_rdata;

    always_comb begin
        next_rdata = '0;
        case ({avs_address_in[DFC_AW-1:2], 2'b00})
            DFC_OFF_CTRL: next_rdata = DFC_DW'(ctrl);
            DFC_OFF_BUS_FB1: next_rdata = DFC_DW'(bus_fb1);
            DFC_OFF_BUS_FB2: next_rdata = DFC_DW'(bus_fb2);
            DFC_OFF_SETPOINT1: next_rdata = DFC_DW'(setpoint1);
            DFC_OFF_SETPOINT2: next_rdata = DFC_DW'(setpoint2);
            DFC_OFF_REF_MIN: next_rdata = DFC_DW'(ref_min);
            DFC_OFF_REF_MAX: next_rdata = DFC_DW'(ref_max);
            DFC_OFF_FB1: next_rdata = DFC_DW'(unsigned'(fb1));
            DFC_OFF_FB2: next_rdata = DFC_DW'(unsigned'(fb2));
            DFC_OFF_FB_COMB: next_rdata = DFC_DW'(unsigned'(feedback_out));
            DFC_OFF_REFERENCE: next_rdata = DFC_DW'(unsigned'(reference_out));
            DFC_OFF_ERROR: next_rdata = DFC_DW'(unsigned'(error_out));
            DFC_OFF_STATUS: next_rdata = DFC_DW'({windup_hold_out, zone_two_out});
            default: next_rdata = '0;
        endcase
    end

    // Captured in the wait cycle so it stands at the completing edge
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            avs_readdata_out <= '0;
        end else if (avs_read_in && !bus_ack) begin
            avs_readdata_out <= next_rdata;
        end
    end

endmodule : dfc_combiner

// File: verif/dfc_combiner_props.sv
`timescale 1ns/1ps
module dfc_combiner_props
    import dfc_pkg::*;
#(
    parameter int W = DFC_W,
    parameter int IW = 28
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [DFC_DW-1:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic signed [W-1:0] analog1_in,
    input wire logic signed [W-1:0] analog2_in,
    input wire logic signed [W-1:0] remote_ref_in,
    input wire dfc_drive_type drive_in,
    input wire logic signed [W+3:0] feedback_out,
    input wire logic signed [W+3:0] reference_out,
    input wire logic signed [W+3:0] error_out,
    input wire logic signed [IW-1:0] integrator_out,
    input wire logic zone_two_out,
    input wire logic windup_hold_out
);
    // ****************************************************************
    // Bus, datapath and integrator checks
    // ****************************************************************
    // Masks the first edges after reset, where $past still sees reset values
    logic [1:0] up_cnt;
    logic req;
    assign req = avs_read_in | avs_write_in;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    sequence s_quiet;
        !$past(avs_write_in) && $stable(analog1_in) && $stable(analog2_in) && up_cnt == 2'h3;
    endsequence
    property p_wait_first; $rose(req) |-> avs_waitrequest_out; endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait state");
    property p_one_wait; req && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state too long");
    property p_rd_hold; !avs_read_in |=> $stable(avs_readdata_out); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
    property p_fb_track; s_quiet |=> $stable(feedback_out); endproperty
    a_fb_track: assert property (p_fb_track) else $error("feedback moved");
    property p_ref_track;
        s_quiet ##0 $stable(remote_ref_in) |=> $stable(reference_out) && $stable(zone_two_out);
    endproperty
    a_ref_track: assert property (p_ref_track) else $error("reference moved");
    property p_hold_load;
        $rose(windup_hold_out) |->
            $past(drive_in.limit_reached) && integrator_out == $past(drive_in.actual_freq);
    endproperty
    a_hold_load: assert property (p_hold_load) else $error("hold without reload");
    property p_hold_still;
        windup_hold_out && $past(windup_hold_out) && !$past(drive_in.limit_reached)
            |-> $stable(integrator_out);
    endproperty
    a_hold_still: assert property (p_hold_still) else $error("held value moved");
    property p_run_sum;
        !windup_hold_out && !$past(windup_hold_out) && !$stable(integrator_out)
            |-> integrator_out == $past(integrator_out) + $past(error_out);
    endproperty
    a_run_sum: assert property (p_run_sum) else $error("bad integration step");
    c_read: cover property (avs_read_in && !avs_waitrequest_out);
    c_hold: cover property ($rose(windup_hold_out));
    c_zone: cover property ($rose(zone_two_out));
endmodule : dfc_combiner_props

bind dfc_combiner dfc_combiner_props #(.W(W), .IW(IW)) u_props (
    .mclk_in(mclk_in), .rst_in(rst_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .analog1_in(analog1_in),
    .analog2_in(analog2_in), .remote_ref_in(remote_ref_in), .drive_in(drive_in),
    .feedback_out(feedback_out), .reference_out(reference_out), .error_out(error_out),
    .integrator_out(integrator_out), .zone_two_out(zone_two_out),
    .windup_hold_out(windup_hold_out));

// File: verif/dfc_transmitter_model.sv
`timescale 1ns/1ps
module dfc_transmitter_model
    import dfc_pkg::*;
(
    input wire logic mclk_in,
    input wire logic signed [DFC_W-1:0] level1_in,
    input wire logic signed [DFC_W-1:0] level2_in,
    output logic signed [DFC_W-1:0] analog1_out,
    output logic signed [DFC_W-1:0] analog2_out
);
    // Both feedback sources sit on the two voltage inputs
    always_ff @(posedge mclk_in) begin
        analog1_out <= level1_in;
        analog2_out <= level2_in;
    end
endmodule : dfc_transmitter_model

// File: verif/dfc_combiner_tb_top.sv
`timescale 1ns/1ps
module dfc_combiner_tb_top;
    import dfc_pkg::*;
    localparam int SC = 4;
    logic mclk_in;
    logic rst_in;
    logic [DFC_AW-1:0] adr;
    logic rd;
    logic wr;
    logic [31:0] wd;
    logic [31:0] rdq;
    logic [31:0] rdata;
    logic wreq;
    logic signed [DFC_W-1:0] lvl1, lvl2, an1, an2, remote;
    dfc_drive_type drive;
    logic signed [DFC_W+3:0] fb, rf, er;
    logic signed [27:0] integ;
    logic zone, hold;
    int bad_count = 0;
    int compares = 0;
    logic [5:0] ra [6] = '{6'h00, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h34};
    logic [31:0] rv [6] = '{32'h22, 32'h0, 32'h0, 32'h8000, 32'h7fff, 32'h0};
    int cf [5] = '{20, 300, 320, -280, 160};
    logic [31:0] zc [4] = '{32'h6a, 32'h6c, 32'h2a, 32'h6a};
    int zr [4] = '{110, 50, 50, 90};
    logic zz [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

    dfc_transmitter_model u_tx (.mclk_in(mclk_in), .level1_in(lvl1), .level2_in(lvl2),
        .analog1_out(an1), .analog2_out(an2));
    dfc_combiner #(.SAMPLE_CYC(SC)) u_dut (.mclk_in(mclk_in), .rst_in(rst_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wd), .avs_byteenable_in(4'hf), .avs_readdata_out(rdq),
        .avs_waitrequest_out(wreq), .analog1_in(an1), .analog2_in(an2),
        .remote_ref_in(remote), .drive_in(drive), .feedback_out(fb), .reference_out(rf),
        .error_out(er), .integrator_out(integ), .zone_two_out(zone),
        .windup_hold_out(hold));

    // ****************************************************************
    // Clock, bus tasks and checks
    // ****************************************************************
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    function automatic logic [31:0] e20(input int v);
        return {12'h0, v[19:0]};
    endfunction : e20
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // Request stands until waitrequest is seen low at a rising edge; the watchdog ends a hang
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge mclk_in);
        end while (wreq !== 1'b0);
        rdata = rdq;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : xfer
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask : settle
    task automatic final_report;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    initial begin
        #100000;
        bad_count++;
        final_report();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        rst_in = 1'b1;
        adr = '0;
        rd = 1'b0;
        wr = 1'b0;
        wd = '0;
        lvl1 = '0;
        lvl2 = '0;
        remote = '0;
        drive = '0;
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            xfer(1'b0, ra[i], 32'h0);
            check("reset reg", rdata, rv[i]);
        end
        xfer(1'b1, 6'h34, 32'h5a);
        xfer(1'b0, 6'h34, 32'h0);
        check("unmapped", rdata, 32'h0);
        xfer(1'b1, DFC_OFF_BUS_FB1, 32'd100);
        xfer(1'b1, DFC_OFF_BUS_FB2, 32'd50);
        xfer(1'b1, DFC_OFF_SETPOINT1, 32'd40);
        xfer(1'b1, DFC_OFF_SETPOINT2, 32'd100);
        xfer(1'b1, DFC_OFF_FB1, 32'h1234);
        remote <= 16'sd10;
        lvl1 <= 16'sd200;
        lvl2 <= -16'sd30;
        // Open loop throughout: feedback must still be formed
        for (int c = 0; c < 5; c++) begin
            xfer(1'b1, DFC_OFF_CTRL, 32'h20 | 32'(c << 1));
            settle(3);
            check("feedback", {12'h0, fb}, e20(cf[c]));
            check("reference", {12'h0, rf}, e20(50));
            check("error", {12'h0, er}, e20(50 - cf[c]));
        end
        xfer(1'b0, DFC_OFF_FB1, 32'h0);
        check("fb1", rdata, e20(300));
        xfer(1'b0, DFC_OFF_FB2, 32'h0);
        check("fb2", rdata, e20(20));
        xfer(1'b1, DFC_OFF_CTRL, 32'h32);
        settle(3);
        check("inverse error", {12'h0, er}, e20(250));
        xfer(1'b1, DFC_OFF_CTRL, 32'h23);
        settle(3);
        check("root feedback", {12'h0, fb}, e20(17));
        xfer(1'b0, DFC_OFF_FB2, 32'h0);
        check("root fb2", rdata, e20(4));
        // Zone modes keep the linear transform
        for (int i = 0; i < 4; i++) begin
            if (i == 3) xfer(1'b1, DFC_OFF_REF_MAX, 32'd80);
            xfer(1'b1, DFC_OFF_CTRL, zc[i]);
            settle(3);
            check("zone reference", {12'h0, rf}, e20(zr[i]));
            check("zone select", {31'h0, zone}, {31'h0, zz[i]});
        end
        xfer(1'b1, DFC_OFF_CTRL, 32'h22);
        drive <= {1'b1, 16'sd123};
        settle(3 * SC);
        check("hold", {31'h0, hold}, 32'h1);
        check("reload", {4'h0, integ}, 32'd123);
        @(posedge mclk_in);
        drive.limit_reached <= 1'b0;
        settle(3 * SC);
        check("still held", {31'h0, hold}, 32'h1);
        @(posedge mclk_in);
        remote <= 16'sd260;
        settle(3 * SC);
        check("released", {31'h0, hold}, 32'h0);
        @(posedge mclk_in);
        remote <= 16'sd10;
        xfer(1'b1, DFC_OFF_CTRL, 32'h02);
        drive.limit_reached <= 1'b1;
        settle(3 * SC);
        check("no hold", {31'h0, hold}, 32'h0);
        final_report();
    end
endmodule : dfc_combiner_tb_top
